// ### switch_debug_pkg.sv
// Offsets, field positions, reset values and encodings of the port debug and subsystem_identifiers register slice.
// Assumes a single core clock domain and 8-bit register offsets.
package switch_debug_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] OFF_PHY_LANE_DELTA = 8'h90;
    localparam logic [7:0] OFF_PHY_MARGIN_RXEQ = 8'h94;
    localparam logic [7:0] OFF_OPMODE_CLKBUF = 8'h98;
    localparam logic [7:0] OFF_DEBUG_CONTROL = 8'h9c;
    localparam logic [7:0] OFF_DEBUG_READOUT = 8'hac;
    localparam logic [7:0] OFF_SUBSYS_CAP = 8'hb0;
    localparam logic [7:0] OFF_SUBSYS_IDS = 8'hb4;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int LANE_MODE_LSB = 0;
    localparam int LANE_MODE_W = 7;
    localparam int DELTA_LSB = 15;
    localparam int DELTA_W = 17;
    localparam logic [6:0] LANE_MODE_RST = 7'h00;
    localparam logic [16:0] DELTA_RST = 17'h00001;
    localparam int MARGIN_LSB = 0;
    localparam logic [15:0] MARGIN_RST = 16'h116b;
    localparam int RXEQ_LSB = 16;
    localparam logic [7:0] RXEQ_RST_UP = 8'h86;
    localparam logic [7:0] RXEQ_RST_DOWN = 8'h00;
    localparam logic [15:0] OPMODE_RST = 16'h0102;
    localparam int CLKBUF_LSB = 16;
    localparam int CLOCK_OUTPUT_POWERDOWN_STRAP_BIT = 20;
    localparam logic [3:0] CLKBUF_PAIR_RST = 4'h7;
    localparam int DBG_PORT_LSB = 0;
    localparam int DBG_TRIG_LSB = 2;
    localparam int DBG_CLEAR_BIT = 6;
    localparam logic [6:0] DBG_CTRL_RST = 7'h00;
    localparam logic [7:0] CAP_ID = 8'h0d;
    localparam logic [7:0] CAP_NEXT_PTR = 8'hc0;
    localparam int CAP_NEXT_LSB = 8;
    localparam int SSID_LSB = 16;

    // ****************************************
    // Training state codes, equal to the trigger select codes
    // ****************************************
    typedef enum logic [3:0] {
        LT_NONE = 4'h0, LT_DETECT = 4'h1, LT_POLLING = 4'h2, LT_CONFIG = 4'h3,
        LT_L0 = 4'h4, LT_L0S = 4'h5, LT_L1 = 4'h6, LT_L2 = 4'h7,
        LT_DISABLE = 4'h8, LT_HOT_RESET = 4'h9, LT_LOOPBACK = 4'ha, LT_RECOVERY = 4'hb
    } train_state_t;
    localparam logic [3:0] TRIG_FIRST = 4'h1;
    localparam logic [3:0] TRIG_LAST = 4'hb;

endpackage : switch_debug_pkg

// ### training_capture.sv
// Capture buffer that records link training state changes after a trigger.
// Assumes state codes arrive on the core clock; reads pop one word each.
`timescale 1ns/1ps
module training_capture #(
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] state_in,
    input wire logic [3:0] trigger_code,
    input wire logic clear,
    input wire logic pop,
    output logic [31:0] head_word,
    output logic recording
);
    import switch_debug_pkg::*;

    logic [31:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] count_q;
    logic [3:0] prev_q;
    logic rec_q;
    logic [23:0] stamp_q;
    logic changed;
    logic trig_valid;
    logic arm;

    // Reserved trigger codes never fire, so the buffer stays idle.
    assign trig_valid = (trigger_code >= TRIG_FIRST) && (trigger_code <= TRIG_LAST);
    assign changed = (state_in != prev_q);
    assign arm = trig_valid && changed && (state_in == trigger_code);
    assign recording = rec_q;
    assign head_word = (count_q != '0) ? mem_q[rd_q] : 32'h0000_0000;

    // Previous state and a free running stamp for each entry.
    always_ff @(posedge mclk) begin
        if (rst) begin
            prev_q <= 4'h0;
            stamp_q <= 24'h00_0000;
        end else begin
            prev_q <= state_in;
            stamp_q <= stamp_q + 24'h00_0001;
        end
    end

    // Arm on entry into the selected state; a clear disarms, but an entry in the same cycle wins.
    always_ff @(posedge mclk) begin
        if (rst) begin
            rec_q <= 1'b0;
        end else if (arm) begin
            rec_q <= 1'b1;
        end else if (clear) begin
            rec_q <= 1'b0;
        end
    end

    // Each entry: old state, new state, stamp. A full buffer drops new entries rather than overwrite history.
    always_ff @(posedge mclk) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
        end else if (clear) begin
            // A trigger entry that meets a clear becomes the first entry of the emptied buffer.
            rd_q <= '0;
            wr_q <= AW'(arm);
            count_q <= (AW+1)'(arm);
            if (arm) begin
                mem_q[0] <= {prev_q, state_in, stamp_q};
            end
        end else begin
            logic push;
            logic take;
            push = (rec_q || arm) && changed && (count_q < (AW+1)'(DEPTH));
            take = pop && (count_q != '0);
            if (push) begin
                mem_q[wr_q] <= {prev_q, state_in, stamp_q};
                wr_q <= wr_q + 1'b1;
            end
            if (take) begin
                rd_q <= rd_q + 1'b1;
            end
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(take);
        end
    end

endmodule : training_capture

// ### switch_phy_debug_ssid_regs.sv
// Register slice with PHY parameters, operation mode, clock buffers, training debug and subsystem IDs.
// Assumes a configuration access port and a side-band management port, both on the core clock mclk.
`timescale 1ns/1ps

module switch_phy_debug_ssid_regs #(
    parameter bit UPSTREAM_PORT = 1'b1,
    parameter int NUM_PORTS = 4,
    parameter int CAPTURE_DEPTH = 16,
    parameter int CAPTURE_AW = 4,
    parameter logic [15:0] SUBSYS_VENDOR_DEFAULT = 16'h5a3c, // Arbitrary value.
    parameter logic [15:0] SUBSYS_DEVICE_DEFAULT = 16'h3c5a // Arbitrary value.
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] cfg_addr,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    input wire logic [7:0] sb_addr,
    input wire logic sb_wr,
    input wire logic sb_rd,
    input wire logic [31:0] sb_wdata,
    output logic [31:0] sb_rdata,
    input wire logic clock_output_powerdown_strap,
    input wire logic vc_zero_negotiation_pending,
    input wire logic scan_mode,
    input wire logic [1:0] package_select,
    input wire logic phy_operating_flag,
    input wire logic debug_mode,
    input wire logic fast_mode,
    input wire logic quiescent_current_test_n,
    input wire logic serial_rom_skip,
    input wire logic [4*NUM_PORTS-1:0] port_train_state,
    output logic reference_clock_output_disable,
    output logic [2:0] reference_clock_output_pair_en,
    output logic debug_recording
);
    import switch_debug_pkg::*;

    // ****************************************
    // Storage
    // ****************************************
    logic [6:0] lane_mode_q;
    logic [16:0] delta_q;
    logic [15:0] margin_q;
    logic [7:0] rxeq_q;
    logic [15:0] opmode_q;
    logic [4:0] clkbuf_q;
    logic strap_load_q;
    logic strap_s1_q;
    logic strap_s2_q;
    logic [6:0] dbg_ctrl_q;
    logic clear_pulse_q;
    logic [15:0] ssvid_q;
    logic [15:0] ssid_q;
    logic [31:0] cfg_rdata_q;
    logic [31:0] sb_rdata_q;
    logic [31:0] head_word;
    logic [3:0] sel_state;
    logic sb_pop;

    // Builds the read word of any offset; the readout word is gated off for configuration access.
    function automatic logic [31:0] read_word(input logic [7:0] addr, input logic sideband);
        logic [31:0] w;
        w = 32'h0000_0000;
        unique case (addr)
            OFF_PHY_LANE_DELTA: begin
                w[LANE_MODE_LSB +: LANE_MODE_W] = lane_mode_q;
                w[DELTA_LSB +: DELTA_W] = delta_q;
            end
            OFF_PHY_MARGIN_RXEQ: begin
                w[MARGIN_LSB +: 16] = margin_q;
                w[RXEQ_LSB +: 8] = rxeq_q;
            end
            OFF_OPMODE_CLKBUF: begin
                w[15:0] = opmode_q;
                w[CLKBUF_LSB +: 5] = clkbuf_q;
            end
            OFF_DEBUG_CONTROL: w[6:0] = dbg_ctrl_q;
            OFF_DEBUG_READOUT: w = sideband ? head_word : 32'h0000_0000;
            OFF_SUBSYS_CAP: begin
                w[7:0] = CAP_ID;
                w[CAP_NEXT_LSB +: 8] = CAP_NEXT_PTR;
            end
            OFF_SUBSYS_IDS: w = {ssid_q, ssvid_q};
            default: w = 32'h0000_0000;
        endcase
        return w;
    endfunction : read_word

    // ****************************************
    // Strap capture
    // ****************************************

    // Two stages before the strap is used. They run through reset, so a strap held for two edges is settled
    // when it is latched in the first cycle after reset release.
    always_ff @(posedge mclk) begin
        strap_s1_q <= clock_output_powerdown_strap;
        strap_s2_q <= strap_s1_q;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            strap_load_q <= 1'b1;
        end else begin
            strap_load_q <= 1'b0;
        end
    end

    // ****************************************
    // Side-band overridable defaults
    // ****************************************

    // The PHY words and IDs are read-only to configuration access but take side-band writes; the RxEQ byte stays 00h in a downstream build.
    always_ff @(posedge mclk) begin
        if (rst) begin
            lane_mode_q <= LANE_MODE_RST;
            delta_q <= DELTA_RST;
            margin_q <= MARGIN_RST;
            rxeq_q <= UPSTREAM_PORT ? RXEQ_RST_UP : RXEQ_RST_DOWN;
            ssvid_q <= SUBSYS_VENDOR_DEFAULT;
            ssid_q <= SUBSYS_DEVICE_DEFAULT;
        end else if (sb_wr) begin
            if (sb_addr == OFF_PHY_LANE_DELTA) begin
                lane_mode_q <= sb_wdata[LANE_MODE_LSB +: LANE_MODE_W];
                delta_q <= sb_wdata[DELTA_LSB +: DELTA_W];
            end
            if (sb_addr == OFF_PHY_MARGIN_RXEQ) begin
                margin_q <= sb_wdata[MARGIN_LSB +: 16];
                rxeq_q <= UPSTREAM_PORT ? sb_wdata[RXEQ_LSB +: 8] : RXEQ_RST_DOWN;
            end
            if (sb_addr == OFF_SUBSYS_IDS) begin
                ssvid_q <= sb_wdata[15:0];
                ssid_q <= sb_wdata[SSID_LSB +: 16];
            end
        end
    end

    // Clock buffer field: pairs reset to 7h, power-down bit takes the settled strap once, in the first cycle after reset release, unless written then.
    always_ff @(posedge mclk) begin
        if (rst) begin
            clkbuf_q <= {1'b0, CLKBUF_PAIR_RST};
        end else if (sb_wr && sb_addr == OFF_OPMODE_CLKBUF) begin
            clkbuf_q <= {sb_wdata[CLOCK_OUTPUT_POWERDOWN_STRAP_BIT], 1'b0, sb_wdata[CLKBUF_LSB +: 3]};
        end else if (strap_load_q) begin
            clkbuf_q[4] <= strap_s2_q;
        end
    end

    // Bit 20 high disables every pair; otherwise each pair follows its own enable.
    assign reference_clock_output_disable = clkbuf_q[4];
    assign reference_clock_output_pair_en = clkbuf_q[4] ? 3'b000 : clkbuf_q[2:0];

    // ****************************************
    // Operation mode snapshot
    // ****************************************

    // The mode flags come from core logic on mclk, so no synchroniser is needed here.
    always_ff @(posedge mclk) begin
        if (rst) begin
            opmode_q <= OPMODE_RST;
        end else begin
            opmode_q <= {7'h00, vc_zero_negotiation_pending, scan_mode, package_select, phy_operating_flag,
                         debug_mode, fast_mode, quiescent_current_test_n, serial_rom_skip};
        end
    end

    // ****************************************
    // Debug control and capture
    // ****************************************

    // Either port may write the control word; the side-band port wins when both write at once.
    always_ff @(posedge mclk) begin
        if (rst) begin
            dbg_ctrl_q <= DBG_CTRL_RST;
            clear_pulse_q <= 1'b0;
        end else begin
            clear_pulse_q <= 1'b0;
            if (sb_wr && sb_addr == OFF_DEBUG_CONTROL) begin
                dbg_ctrl_q <= sb_wdata[6:0];
                clear_pulse_q <= sb_wdata[DBG_CLEAR_BIT];
            end else if (cfg_wr && cfg_addr == OFF_DEBUG_CONTROL) begin
                dbg_ctrl_q <= cfg_wdata[6:0];
                clear_pulse_q <= cfg_wdata[DBG_CLEAR_BIT];
            end
        end
    end

    // Port select picks one state lane; a select beyond the port count watches port zero.
    assign sel_state = (int'(dbg_ctrl_q[DBG_PORT_LSB +: 2]) < NUM_PORTS) ?
                       port_train_state[4*dbg_ctrl_q[DBG_PORT_LSB +: 2] +: 4] : port_train_state[3:0];
    assign sb_pop = sb_rd && sb_addr == OFF_DEBUG_READOUT;

    training_capture #(
        .DEPTH(CAPTURE_DEPTH),
        .AW(CAPTURE_AW)
    ) u_capture (
        .mclk(mclk),
        .rst(rst),
        .state_in(sel_state),
        .trigger_code(dbg_ctrl_q[DBG_TRIG_LSB +: 4]),
        .clear(clear_pulse_q),
        .pop(sb_pop),
        .head_word(head_word),
        .recording(debug_recording)
    );

    // ****************************************
    // Read data
    // ****************************************

    // Read data registers one cycle after the read strobe and holds until the next read.
    always_ff @(posedge mclk) begin
        if (rst) begin
            cfg_rdata_q <= 32'h0000_0000;
            sb_rdata_q <= 32'h0000_0000;
        end else begin
            if (cfg_rd) begin
                cfg_rdata_q <= read_word(cfg_addr, 1'b0);
            end
            if (sb_rd) begin
                sb_rdata_q <= read_word(sb_addr, 1'b1);
            end
        end
    end

    assign cfg_rdata = cfg_rdata_q;
    assign sb_rdata = sb_rdata_q;

endmodule : switch_phy_debug_ssid_regs

// ### regs_checker_sva.sv
// Concurrent checks on the register slice ports: read data, clock buffer outputs and capture arming.
// Assumes the single clock mclk and the synchronous active-high rst of the top module.
`timescale 1ns/1ps
module regs_checker #(
    parameter int NUM_PORTS = 4
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] cfg_addr,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [31:0] cfg_wdata,
    input wire logic [31:0] cfg_rdata,
    input wire logic [7:0] sb_addr,
    input wire logic sb_wr,
    input wire logic sb_rd,
    input wire logic [31:0] sb_wdata,
    input wire logic [31:0] sb_rdata,
    input wire logic reference_clock_output_disable,
    input wire logic [2:0] reference_clock_output_pair_en,
    input wire logic [4*NUM_PORTS-1:0] port_train_state,
    input wire logic debug_recording
);
    default clocking ck @(posedge mclk); endclocking
    default disable iff (rst);

    // ********
    // Sequences
    // ********
    // A side-band write to the control word outranks the configuration write, so it is excluded.
    sequence ctrl_write;
        cfg_wr && cfg_addr == 8'h9c && !(sb_wr && sb_addr == 8'h9c);
    endsequence
    sequence ctrl_read;
        cfg_rd && !cfg_wr && !sb_wr && cfg_addr == 8'h9c;
    endsequence
    sequence ids_write;
        sb_wr && sb_addr == 8'hb4;
    endsequence
    // The host model leaves one idle edge after a transfer, so the identifiers are read back two edges later.
    sequence ids_read;
        !sb_wr ##1 (cfg_rd && !cfg_wr && !sb_wr && cfg_addr == 8'hb4);
    endsequence

    // ********
    // Assertions
    // ********
    a_pairs_gated: assert property (reference_clock_output_disable |-> reference_clock_output_pair_en == 3'b000)
        else $error("Output pairs enabled while outputs disabled.");
    a_ctrl_readback: assert property (ctrl_write ##1 (!cfg_wr && !sb_wr) ##1 ctrl_read |=>
        cfg_rdata == {25'd0, $past(cfg_wdata[6:0], 3)})
        else $error("Control word read-back differs from the write.");
    a_readout_hidden: assert property (cfg_rd && cfg_addr == 8'hac |=> cfg_rdata == 32'h0)
        else $error("Debug readout visible on configuration port.");
    a_cap_header: assert property (cfg_rd && cfg_addr == 8'hb0 |=> cfg_rdata == 32'h0000c00d)
        else $error("Capability header wrong.");
    a_mode_reserved: assert property (cfg_rd && cfg_addr == 8'h98 |=> cfg_rdata[31:21] == 11'd0 && !cfg_rdata[19])
        else $error("Reserved mode word bits set.");
    a_ids_replace: assert property (ids_write ##1 ids_read |=> cfg_rdata == $past(sb_wdata, 3))
        else $error("Subsystem identifiers not replaced.");
    a_clkbuf_drive: assert property (sb_wr && sb_addr == 8'h98 && !$past(rst) |=>
        reference_clock_output_disable == $past(sb_wdata[20]) &&
        reference_clock_output_pair_en == ($past(sb_wdata[20]) ? 3'b000 : $past(sb_wdata[18:16])))
        else $error("Clock buffer outputs do not follow the write.");
    a_clear_disarm: assert property (ctrl_write ##0 cfg_wdata[6] ##1 (port_train_state == '0) |=> !debug_recording)
        else $error("Capture still armed after clear.");
endmodule : regs_checker

bind switch_phy_debug_ssid_regs regs_checker #(.NUM_PORTS(NUM_PORTS)) regs_checker_i (.mclk(mclk), .rst(rst),
    .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .sb_addr(sb_addr), .sb_wr(sb_wr), .sb_rd(sb_rd), .sb_wdata(sb_wdata), .sb_rdata(sb_rdata),
    .reference_clock_output_disable(reference_clock_output_disable),
    .reference_clock_output_pair_en(reference_clock_output_pair_en), .port_train_state(port_train_state),
    .debug_recording(debug_recording));

// ### sb_host.sv
// Side-band management host model issuing word writes and reads.
// Assumes calls start one small delay after a rising edge of mclk.
`timescale 1ns/1ps
module sb_host (
    input wire logic mclk,
    output logic [7:0] sb_addr,
    output logic sb_wr,
    output logic sb_rd,
    output logic [31:0] sb_wdata
);
    // Idle host: strobes low.
    initial begin
        sb_addr = 8'h00;
        sb_wr = 1'b0;
        sb_rd = 1'b0;
        sb_wdata = 32'h0;
    end

    // One-strobe transfer, then an idle edge; released lines show the inverse so stale values never match.
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        sb_addr = a;
        sb_wdata = d;
        sb_wr = wr;
        sb_rd = !wr;
        @(posedge mclk);
        #1;
        sb_wr = 1'b0;
        sb_rd = 1'b0;
        sb_addr = ~a;
        sb_wdata = ~d;
        @(posedge mclk);
        #1;
    endtask : xfer
endmodule : sb_host

// ### tb_top.sv
// Self-checking bench for the register slice, side-band host model attached.
// Assumes a 10 MHz core clock and an upstream build with four ports.
`timescale 1ns/1ps
module tb_top;
    import switch_debug_pkg::*;
    typedef struct {bit sb; logic [31:0] exp; logic [31:0] mask;} note_t;
    localparam logic [15:0] VEND = 16'h1357; // Arbitrary value.
    localparam logic [15:0] DEVI = 16'h2468; // Arbitrary value.
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic strap = 1'b1;
    logic [7:0] cfg_addr = 8'h00;
    logic cfg_wr = 1'b0;
    logic cfg_rd = 1'b0;
    logic [31:0] cfg_wdata = 32'h0;
    logic [8:0] om = 9'h102;
    logic [15:0] lts = 16'h0;
    logic [4:0] cb = 5'h17;
    logic [31:0] d;
    logic [1:0] p;
    logic [1:0] q;
    logic pend_c = 1'b0;
    logic pend_s = 1'b0;
    wire logic [7:0] sb_addr;
    wire logic sb_wr;
    wire logic sb_rd;
    wire logic [31:0] sb_wdata;
    wire logic [31:0] cfg_rdata;
    wire logic [31:0] sb_rdata;
    wire logic dis;
    wire logic [2:0] pen;
    wire logic rec;
    note_t notes[$];
    note_t n;
    int failures = 0;
    int compares = 0;
    int seed = 32'h56b84d61;
    logic [7:0] ro_offs [7] = '{8'h90, 8'h94, 8'h98, 8'hac, 8'hb0, 8'hb4, 8'ha0};

    switch_phy_debug_ssid_regs #(.SUBSYS_VENDOR_DEFAULT(VEND), .SUBSYS_DEVICE_DEFAULT(DEVI))
        switch_phy_debug_ssid_regs_i (.mclk(mclk), .rst(rst), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr),
        .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .sb_addr(sb_addr), .sb_wr(sb_wr),
        .sb_rd(sb_rd), .sb_wdata(sb_wdata), .sb_rdata(sb_rdata), .clock_output_powerdown_strap(strap),
        .vc_zero_negotiation_pending(om[8]), .scan_mode(om[7]), .package_select(om[6:5]),
        .phy_operating_flag(om[4]), .debug_mode(om[3]), .fast_mode(om[2]), .quiescent_current_test_n(om[1]),
        .serial_rom_skip(om[0]), .port_train_state(lts), .reference_clock_output_disable(dis),
        .reference_clock_output_pair_en(pen), .debug_recording(rec));
    sb_host sb_host_i (.mclk(mclk), .sb_addr(sb_addr), .sb_wr(sb_wr), .sb_rd(sb_rd), .sb_wdata(sb_wdata));

    // Free-running core clock.
    initial begin
        forever #50 mclk = ~mclk;
    end

    // Read data stands from one edge after the read, so it is compared at the following edge against the oldest note.
    always @(posedge mclk) begin
        if (pend_c || pend_s) begin
            n = notes.pop_front();
            chk((n.sb ? sb_rdata : cfg_rdata) & n.mask, n.exp);
        end
        pend_c <= cfg_rd;
        pend_s <= sb_rd;
    end

    // A hang is cut short well beyond the expected run of under a thousand cycles.
    initial begin
        #2000000;
        failures++;
        tally_and_finish();
    end

    // ********
    // Tasks
    // ********
    task automatic cyc;
        @(posedge mclk);
        #1;
    endtask : cyc

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Strobes last one edge and an idle edge follows, so a strobe is never lowered and raised at once.
    task automatic cwr(input logic [7:0] a, input logic [31:0] v);
        cfg_addr = a;
        cfg_wdata = v;
        cfg_wr = 1'b1;
        cyc();
        cfg_wr = 1'b0;
        cyc();
    endtask : cwr

    task automatic crd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
        notes.push_back('{1'b0, e, m});
        cfg_addr = a;
        cfg_rd = 1'b1;
        cyc();
        cfg_rd = 1'b0;
        cyc();
    endtask : crd

    task automatic sbrd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
        notes.push_back('{1'b1, e, m});
        sb_host_i.xfer(1'b0, a, 32'h0);
    endtask : sbrd

    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish

    // ********
    // Main sequence
    // ********
    initial begin
        repeat (16) @(posedge mclk);
        #1;
        rst = 1'b0;
        repeat (4) cyc();
        // Second pass proves configuration writes leave read-only words alone.
        for (int i = 0; i < 2; i++) begin
            chk({28'd0, dis, pen}, {28'd0, 1'b1, 3'b000});
            crd(8'h90, 32'h00008000);
            crd(8'h94, 32'h0086116b);
            crd(8'h98, {11'd0, cb, 7'd0, om});
            crd(8'h9c, 32'h0);
            crd(8'hac, 32'h0);
            crd(8'hb0, 32'h0000c00d);
            crd(8'hb4, {DEVI, VEND});
            crd(8'ha0, 32'h0);
            foreach (ro_offs[j]) cwr(ro_offs[j], $random(seed));
        end
        $display("Done: reset and read-only values");
        repeat (6) begin
            d = $random(seed);
            cwr(8'h9c, d);
            crd(8'h9c, {25'd0, d[6:0]});
            om = 9'($random(seed));
            repeat (2) cyc();
            crd(8'h98, {11'd0, cb, 7'd0, om});
        end
        $display("Done: control and mode snapshot");
        for (int k = 0; k < 4; k++) begin
            d = $random(seed);
            d[20] = k[0];
            sb_host_i.xfer(1'b1, 8'h98, d);
            cb = {d[20], 1'b0, d[18:16]};
            chk({28'd0, dis, pen}, {28'd0, cb[4], cb[4] ? 3'b000 : cb[2:0]});
            sbrd(8'h98, {11'd0, cb, 7'd0, om});
            sb_host_i.xfer(1'b1, 8'h90, d);
            crd(8'h90, d & 32'hffff807f);
            sb_host_i.xfer(1'b1, 8'h94, d);
            sbrd(8'h94, d & 32'h00ffffff);
            sb_host_i.xfer(1'b1, 8'hb4, d);
            crd(8'hb4, d);
        end
        $display("Done: side-band overrides");
        // Trigger codes 1 to 15, reserved ones too; a wrong port entering the state must not arm.
        for (int c = 1; c < 16; c++) begin
            p = 2'(c);
            q = p + 2'd1;
            lts = 16'h0;
            cyc();
            cwr(8'h9c, {25'd0, 1'b1, 4'(c), p});
            lts[4*q +: 4] = 4'(c);
            repeat (3) cyc();
            chk({31'd0, rec}, 32'h0);
            lts[4*p +: 4] = 4'(c);
            repeat (3) cyc();
            chk({31'd0, rec}, {31'd0, c < 12});
            if (c < 12) begin
                sbrd(8'hac, {4'h0, 4'(c), 24'h0}, 32'hff000000);
                lts[4*p +: 4] = 4'(c + 1);
                cyc();
                sbrd(8'hac, {4'(c), 4'(c + 1), 24'h0}, 32'hff000000);
            end else begin
                sbrd(8'hac, 32'h0);
            end
            crd(8'hac, 32'h0);
        end
        $display("Done: capture triggers");
        // Reset again with the strap low: outputs come back enabled with all three pairs on.
        strap = 1'b0;
        rst = 1'b1;
        repeat (4) cyc();
        rst = 1'b0;
        repeat (2) cyc();
        chk({28'd0, dis, pen}, {28'd0, 1'b0, 3'b111});
        crd(8'h98, {11'd0, 5'h07, 7'd0, om});
        $display("Done: strap low reset");
        tally_and_finish();
    end
endmodule : tb_top
